// >>> hdl/dq_sync.sv
// Two-stage synchroniser for the flash data pins
`timescale 1ns/1ps
module dq_sync (
   // Clock and reset
   input  wire logic                              mclk,
   input  wire logic                              rst_n,
   // Asynchronous data in, synchronised data out
   input  wire logic [flash_host_pkg::DATA_W-1:0] d,
   output logic      [flash_host_pkg::DATA_W-1:0] q
);

   logic [flash_host_pkg::DATA_W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

// >>> hdl/flash_host.sv
// Host controller that sequences commands on the flash memory pins
`timescale 1ns/1ps
module flash_host (
   // Clock and reset
   input  wire logic                              mclk,
   input  wire logic                              rst_n,
   // User request port
   input  wire logic                              req_valid,
   input  wire flash_host_pkg::req_s              req,
   output logic                                   req_ready,
   output flash_host_pkg::resp_s                  resp,
   // Boot block write permission, level
   input  wire logic                              boot_write_allow,
   // Flash pins
   output flash_host_pkg::pins_s                  pins,
   input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in
);

   typedef enum logic [3:0] {
      ST_RESET   = 4'h0,
      ST_WAKE    = 4'h1,
      ST_IDLE    = 4'h3,
      ST_CMD1    = 4'h2,
      ST_CMD2    = 4'h6,
      ST_POLL    = 4'h7,
      ST_RESTORE = 4'h5,
      ST_DONE    = 4'h4,
      ST_READ    = 4'hc
   } state_e;

   state_e                            state_r;
   logic [7:0]                        cnt_r;
   flash_host_pkg::req_s              req_r;
   flash_host_pkg::seq_s              seq_r;
   logic [flash_host_pkg::DATA_W-1:0] dq_s;
   logic                              wr_last;
   logic                              rd_last;
   logic                              strobe_on;
   logic                              oe_on;

   // Data pins are asynchronous to mclk
   dq_sync u_dq_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (dq_in),
      .q     (dq_s)
   );

   // Position inside a bus cycle
   assign wr_last   = (cnt_r == flash_host_pkg::WR_END);
   assign rd_last   = (cnt_r == flash_host_pkg::RD_END);
   assign strobe_on = (cnt_r >= 8'h01) && (cnt_r <= flash_host_pkg::WE_CYC);
   assign oe_on     = (cnt_r >= 8'h01) && (cnt_r < flash_host_pkg::RD_END);

   // Sequencer state and cycle counter
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= ST_RESET;
         cnt_r   <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         unique case (state_r)
            ST_RESET: if (cnt_r == flash_host_pkg::RESET_CYC - 8'h01) begin
               state_r <= ST_WAKE;
               cnt_r   <= 8'h00;
            end
            ST_WAKE: if (cnt_r == flash_host_pkg::WAKE_CYC - 8'h01) begin
               state_r <= ST_IDLE;
               cnt_r   <= 8'h00;
            end
            ST_IDLE: begin
               cnt_r <= 8'h00;
               if (req_valid && req_ready) begin
                  state_r <= ST_CMD1;
               end
            end
            ST_CMD1: if (wr_last) begin
               cnt_r <= 8'h00;
               if (seq_r.two) begin
                  state_r <= ST_CMD2;
               end else if (seq_r.poll) begin
                  state_r <= ST_POLL;
               end else if (seq_r.read) begin
                  state_r <= ST_READ;
               end else begin
                  state_r <= ST_DONE;
               end
            end
            ST_CMD2: if (wr_last) begin
               cnt_r   <= 8'h00;
               state_r <= seq_r.poll ? ST_POLL : ST_DONE;
            end
            ST_POLL: if (rd_last) begin
               cnt_r <= 8'h00;
               if (dq_s[flash_host_pkg::MACHINE_READY_BIT]) begin
                  state_r <= ST_RESTORE;
               end
            end
            ST_READ: if (rd_last) begin
               cnt_r   <= 8'h00;
               state_r <= ST_DONE;
            end
            ST_RESTORE: if (wr_last) begin
               cnt_r   <= 8'h00;
               state_r <= ST_DONE;
            end
            ST_DONE: begin
               cnt_r   <= 8'h00;
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_RESET;
               cnt_r   <= 8'h00;
            end
         endcase
      end
   end

   // Request capture and command plan
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         req_r <= '0;
         seq_r <= '0;
      end else if (state_r == ST_IDLE && req_valid && req_ready) begin
         req_r <= req;
         seq_r <= flash_host_pkg::plan(req.op);
      end
   end

   // Ready to accept a request while idle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= (state_r == ST_DONE)
                    || (state_r == ST_IDLE && !req_valid)
                    || (state_r == ST_WAKE && cnt_r == flash_host_pkg::WAKE_CYC - 8'h01);
      end
   end

   // Answer: status or read data, done pulse
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         resp <= '0;
      end else begin
         resp.done <= (state_r == ST_DONE);
         if ((state_r == ST_READ && rd_last)
             || (state_r == ST_POLL && rd_last && dq_s[flash_host_pkg::MACHINE_READY_BIT])) begin
            resp.rdata <= dq_s;
         end
      end
   end

   // Pin drive; registered so every pin leaves a flip-flop
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b0,
                   wp_n: 1'b0, addr: '0, dq_out: '0, dq_oe_n: 1'b1};
      end else begin
         pins.reset_powerdown_n <= (state_r != ST_RESET);
         // Boot blocks stay guarded unless the user allows them
         pins.wp_n <= boot_write_allow;
         pins.addr <= req_r.addr;
         unique case (state_r)
            ST_CMD1, ST_CMD2, ST_RESTORE: begin
               // Strobe rises one cycle before select and data release
               pins.ce_n    <= wr_last;
               pins.oe_n    <= 1'b1;
               pins.we_n    <= !strobe_on;
               pins.dq_oe_n <= wr_last;
               if (state_r == ST_CMD1) begin
                  pins.dq_out <= seq_r.cmd1;
               end else if (state_r == ST_CMD2) begin
                  pins.dq_out <= seq_r.use_wdata ? req_r.wdata : seq_r.cmd2;
               end else begin
                  pins.dq_out <= flash_host_pkg::CMD_READ_ARRAY;
               end
            end
            ST_POLL, ST_READ: begin
               pins.ce_n    <= rd_last;
               pins.oe_n    <= !oe_on;
               pins.we_n    <= 1'b1;
               pins.dq_oe_n <= 1'b1;
            end
            default: begin
               pins.ce_n    <= 1'b1;
               pins.oe_n    <= 1'b1;
               pins.we_n    <= 1'b1;
               pins.dq_oe_n <= 1'b1;
            end
         endcase
      end
   end

endmodule

// >>> hdl/flash_host_pkg.sv
// Package: timing, command codes, operations and carriers for the flash host controller
package flash_host_pkg;

   // Clock and pin widths
   localparam int CLK_NS = 40;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;

   // Least time to whole clock cycles, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Times in ns
   localparam int T_RESET_NS   = 100;   // Least reset pulse
   localparam int T_WAKE_NS    = 1000;  // Reset release to valid read data
   localparam int T_RECOVER_NS = 1000;  // Reset release to first command write
   localparam int T_WE_NS      = 100;   // Write strobe low time
   localparam int T_ACCESS_NS  = 120;   // Output enable to data valid

   // Cycle counts derived from the times
   localparam logic [7:0] RESET_CYC  = 8'(cyc_up(T_RESET_NS));
   localparam logic [7:0] WAKE_CYC   = 8'(cyc_up((T_WAKE_NS > T_RECOVER_NS) ?
                                                 T_WAKE_NS : T_RECOVER_NS));
   localparam logic [7:0] WE_CYC     = 8'(cyc_up(T_WE_NS));
   localparam logic [7:0] ACCESS_CYC = 8'(cyc_up(T_ACCESS_NS));
   localparam logic [7:0] WR_END     = WE_CYC + 8'h02;      // Setup, strobe, hold
   localparam logic [7:0] RD_END     = ACCESS_CYC + 8'h04;  // Includes pin sync delay

   // Status bit that reports the write machine ready
   localparam int MACHINE_READY_BIT = 7;

   // Command codes on the data pins
   localparam logic [DATA_W-1:0] CMD_READ_ARRAY   = 16'h00ff;
   localparam logic [DATA_W-1:0] CMD_READ_ID      = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_READ_STATUS  = 16'h0070;
   localparam logic [DATA_W-1:0] CMD_CLEAR_STATUS = 16'h0050;
   localparam logic [DATA_W-1:0] CMD_BLOCK_ERASE  = 16'h0020;
   localparam logic [DATA_W-1:0] CMD_CHIP_ERASE   = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_WORD_WRITE   = 16'h0040;
   localparam logic [DATA_W-1:0] CMD_SUSPEND      = 16'h00b0;
   localparam logic [DATA_W-1:0] CMD_CONFIRM      = 16'h00d0;
   localparam logic [DATA_W-1:0] CMD_LOCK_SETUP   = 16'h0060;
   localparam logic [DATA_W-1:0] CMD_SET_LOCK     = 16'h0001;
   localparam logic [DATA_W-1:0] CMD_PERM_LOCK    = 16'h00f1;

   // Operations a user may request
   typedef enum logic [3:0] {
      OP_READ_ARRAY   = 4'h0,
      OP_READ_ID      = 4'h1,
      OP_READ_STATUS  = 4'h2,
      OP_CLEAR_STATUS = 4'h3,
      OP_WORD_WRITE   = 4'h4,
      OP_BLOCK_ERASE  = 4'h5,
      OP_CHIP_ERASE   = 4'h6,
      OP_SUSPEND      = 4'h7,
      OP_RESUME       = 4'h8,
      OP_SET_LOCK     = 4'h9,
      OP_CLEAR_LOCKS  = 4'ha,
      OP_PERM_LOCK    = 4'hb
   } op_e;

   // User request and answer
   typedef struct packed {
      op_e               op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_s;

   typedef struct packed {
      logic              done;
      logic [DATA_W-1:0] rdata;
   } resp_s;

   // Flash pins driven by the host; dq_oe_n low while the host drives data
   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              reset_powerdown_n;
      logic              wp_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe_n;
   } pins_s;

   // Bus cycle plan for one operation
   typedef struct packed {
      logic [DATA_W-1:0] cmd1;
      logic              two;
      logic              use_wdata;
      logic [DATA_W-1:0] cmd2;
      logic              poll;
      logic              read;
   } seq_s;

   // Translate an operation into its command cycles
   function automatic seq_s plan(input op_e op);
      seq_s s;
      s = '{cmd1: CMD_READ_ARRAY, two: 1'b0, use_wdata: 1'b0, cmd2: CMD_CONFIRM,
            poll: 1'b0, read: 1'b0};
      unique case (op)
         OP_READ_ARRAY:   s.read = 1'b1;
         OP_READ_ID:      begin s.cmd1 = CMD_READ_ID;     s.read = 1'b1; end
         OP_READ_STATUS:  begin s.cmd1 = CMD_READ_STATUS; s.read = 1'b1; end
         OP_CLEAR_STATUS: s.cmd1 = CMD_CLEAR_STATUS;
         OP_WORD_WRITE:   begin
            s.cmd1 = CMD_WORD_WRITE; s.two = 1'b1; s.use_wdata = 1'b1; s.poll = 1'b1;
         end
         OP_BLOCK_ERASE:  begin s.cmd1 = CMD_BLOCK_ERASE; s.two = 1'b1; s.poll = 1'b1; end
         OP_CHIP_ERASE:   begin s.cmd1 = CMD_CHIP_ERASE;  s.two = 1'b1; s.poll = 1'b1; end
         OP_SUSPEND:      begin s.cmd1 = CMD_SUSPEND;     s.poll = 1'b1; end
         OP_RESUME:       s.cmd1 = CMD_CONFIRM;
         OP_SET_LOCK:     begin
            s.cmd1 = CMD_LOCK_SETUP; s.two = 1'b1; s.cmd2 = CMD_SET_LOCK; s.poll = 1'b1;
         end
         OP_CLEAR_LOCKS:  begin s.cmd1 = CMD_LOCK_SETUP; s.two = 1'b1; s.poll = 1'b1; end
         OP_PERM_LOCK:    begin
            s.cmd1 = CMD_LOCK_SETUP; s.two = 1'b1; s.cmd2 = CMD_PERM_LOCK; s.poll = 1'b1;
         end
         default:         s.read = 1'b1;
      endcase
      return s;
   endfunction

endpackage

// >>> verification/flash_host_properties.sv
// Assertions on the flash host ports
`timescale 1ns/1ps
module flash_host_checker (
   // Clock and reset
   input wire logic                  mclk,
   input wire logic                  rst_n,
   // User port
   input wire logic                  req_valid,
   input wire logic                  req_ready,
   input wire flash_host_pkg::resp_s resp,
   // Flash side
   input wire logic                  boot_write_allow,
   input wire flash_host_pkg::pins_s pins
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   logic [7:0] up_r;

   // Cycles since the flash left reset, saturating
   always_ff @(posedge mclk)
      if (!pins.reset_powerdown_n) up_r <= 8'h00;
      else if (up_r != 8'hff) up_r <= up_r + 8'h01;

   sequence strobe_s;
      !pins.we_n [*3] ##1 pins.we_n;
   endsequence
   sequence access_s;
      // Output enable stands six cycles of the eight-cycle read
      !pins.oe_n [*6] ##1 pins.oe_n;
   endsequence

   a_strobe_width: assert property ($fell(pins.we_n) |-> strobe_s)
      else $error("write strobe width wrong");
   a_read_access: assert property ($fell(pins.oe_n) |-> access_s)
      else $error("output enable width wrong");
   a_read_pins: assert property (!pins.oe_n |-> pins.we_n && !pins.ce_n &&
      pins.dq_oe_n && pins.reset_powerdown_n) else $error("read pins wrong");
   a_write_pins: assert property (!pins.we_n |-> !pins.ce_n &&
      !pins.dq_oe_n && pins.reset_powerdown_n) else $error("write pins wrong");
   a_reset_pulse: assert property ($rose(rst_n) |-> !pins.reset_powerdown_n [*3])
      else $error("flash reset too short");
   a_wake_wait: assert property (!(pins.we_n && pins.oe_n) |-> up_r >= 8'h19)
      else $error("access too soon after reset");
   a_two_cycle: assert property ($rose(pins.we_n) && pins.dq_out inside
      {16'h0020, 16'h0030, 16'h0040, 16'h0060} |-> ##[1:8] $fell(pins.we_n))
      else $error("second command cycle missing");
   a_wp_follow: assert property ($past(rst_n) |-> pins.wp_n == $past(boot_write_allow))
      else $error("write protect not following");
   a_take_drop: assert property (req_valid && req_ready |=> !req_ready)
      else $error("ready held after take");
   // Ready stands with done; a take right after done is legal
   a_done_ready: assert property (resp.done |-> req_ready ##1 !resp.done)
      else $error("done not a pulse");
endmodule

bind flash_host flash_host_checker i_flash_host_checker (.mclk(mclk), .rst_n(rst_n),
   .req_valid(req_valid), .req_ready(req_ready), .resp(resp),
   .boot_write_allow(boot_write_allow), .pins(pins));

// >>> verification/flash_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module flash_host_tb;
   logic                  mclk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  req_valid = 1'b0;
   flash_host_pkg::req_s  req = '0;
   logic                  boot_write_allow = 1'b0;
   logic                  req_ready;
   flash_host_pkg::resp_s resp;
   flash_host_pkg::pins_s pins;
   logic [15:0]           dq, rd;
   int                    miscompares = 0;
   int                    compares = 0;
   int                    cyc = 0;
   int                    took = 0;

   // 25 MHz clock
   always #20 mclk = ~mclk;

   flash_host i_flash_host (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .resp(resp), .boot_write_allow(boot_write_allow),
      .pins(pins), .dq_in(dq));
   flash_model i_flash_model (.mclk(mclk), .p(pins), .dq(dq));

   task automatic give_verdict();
      if (miscompares == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Hang guard, far above the 1200 or so cycles needed
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Duration compare, a lower bound
   task automatic chk_min(input int got, input int lo);
      compares++;
      if (got < lo) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, lo);
      end
   endtask

   // Hold the request until the edge that takes it
   task automatic take(input logic [3:0] o, input logic [19:0] a, input logic [15:0] w);
      @(posedge mclk);
      #1;
      req = '{op: flash_host_pkg::op_e'(o), addr: a, wdata: w};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
   endtask

   // Whole operation; polled ones may take long
   task automatic op(input logic [3:0] o, input logic [19:0] a, input logic [15:0] w);
      take(o, a, w);
      took = 1;
      while (resp.done !== 1'b1 && took < 9000) begin
         @(posedge mclk);
         #1;
         took++;
      end
      // A stuck operation is a mismatch, not a silent pass
      if (took >= 9000) miscompares++;
      rd = resp.rdata;
   endtask

   task automatic rd_chk(input logic [19:0] a, input logic [15:0] e);
      op(4'h0, a, 16'h0000);
      chk(rd, e);
   endtask

   task automatic t_write();
      op(4'h4, 20'h12345, 16'h1234);
      chk(rd, 16'h0080);
      rd_chk(20'h12345, 16'h1234);
      rd_chk(20'h12346, 16'hffff);
      op(4'h2, 20'h00000, 16'h0000);
      chk(rd, 16'h0080);
      op(4'h3, 20'h00000, 16'h0000);
      op(4'h1, 20'h00000, 16'h0000);
      chk(rd, i_flash_model.MFR_CODE);
      op(4'h1, 20'h00001, 16'h0000);
      chk(rd, i_flash_model.DEV_CODE);
   endtask

   // Locked block, boot guard and chip erase
   task automatic t_lock();
      op(4'h4, 20'h40010, 16'h0f0f);
      op(4'h9, 20'h40000, 16'h0000);
      op(4'h1, 20'h40002, 16'h0000);
      chk(rd, 16'h0001);
      op(4'h4, 20'h40011, 16'h0f0f);
      rd_chk(20'h40011, 16'hffff);
      op(4'h4, 20'h00010, 16'h3333);
      rd_chk(20'h00010, 16'hffff);
      boot_write_allow = 1'b1;
      op(4'h4, 20'h00010, 16'h3333);
      rd_chk(20'h00010, 16'h3333);
      op(4'h6, 20'h00000, 16'h0000);
      rd_chk(20'h00010, 16'hffff);
      rd_chk(20'h40010, 16'h0f0f);
      op(4'ha, 20'h00000, 16'h0000);
      op(4'h4, 20'h40011, 16'h0f0f);
      rd_chk(20'h40011, 16'h0f0f);
   endtask

   // Erase at the small/main block border
   task automatic t_erase();
      op(4'h4, 20'h07fff, 16'h5555);
      op(4'h4, 20'h08000, 16'h3333);
      op(4'h5, 20'h0ffff, 16'h0000);
      rd_chk(20'h08000, 16'hffff);
      rd_chk(20'h07fff, 16'h5555);
      i_flash_model.busy_cyc = 300;
      op(4'h5, 20'h08000, 16'h0000);
      chk_min(took, 300);
      i_flash_model.busy_cyc = 6;
      op(4'h7, 20'h00000, 16'h0000);
      op(4'h8, 20'h00000, 16'h0000);
      op(4'hb, 20'h00000, 16'h0000);
   endtask

   // Reset in mid erase aborts it
   task automatic t_abort();
      i_flash_model.busy_cyc = 300;
      take(4'h5, 20'h08000, 16'h0000);
      repeat (60) @(posedge mclk);
      #1;
      rst_n = 1'b0;
      repeat (12) @(posedge mclk);
      #1;
      chk({15'h0, pins.reset_powerdown_n}, 16'h0000);
      rst_n = 1'b1;
      i_flash_model.busy_cyc = 6;
      op(4'h2, 20'h00000, 16'h0000);
      chk(rd, 16'h0080);
      // Block erase cleared the main block earlier; the parameter word survives
      rd_chk(20'h07fff, 16'h5555);
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      t_write();
      t_lock();
      t_erase();
      t_abort();
      give_verdict();
   end
endmodule

// >>> verification/flash_model.sv
// Behavioural model of the flash memory at its pins
`timescale 1ns/1ps
module flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h00a5, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h005c  // Arbitrary value
) (
   // Timing for the write machine
   input  wire logic                  mclk,
   // Host pins and data wire
   input  wire flash_host_pkg::pins_s p,
   output logic [15:0]                dq
);
   logic [15:0] mem [int];
   logic [38:0] lk = '0;
   logic [15:0] c1 = '0;
   logic [15:0] c2, oq;
   logic [19:0] wa;
   logic [7:0]  sr = 8'h80;
   logic [1:0]  md = 2'h0;
   logic        susp = 1'b0;
   int          bz = 0;
   int          busy_cyc = 6;

   // eight small blocks, then main blocks
   function automatic int blk(input logic [19:0] a);
      return (a < 20'h08000) ? int'(a[14:12]) : 7 + int'(a[19:15]);
   endfunction

   // lock bits; boot blocks also follow protect
   function automatic bit prot(input logic [19:0] a);
      return lk[blk(a)] || (blk(a) < 2 && !p.wp_n);
   endfunction

   // latch on strobe rise, never in reset
   always @(posedge p.we_n) begin
      if (p.reset_powerdown_n && !p.ce_n) begin
         if (c1 != 16'h0000) begin
            oq = c1;
            c2 = p.dq_out;
            wa = p.addr;
            c1 = '0;
            md = 2'h2;
            sr = 8'h80;
            if (!((oq == 16'h0040 || oq == 16'h0020) && prot(wa))) begin
               bz = busy_cyc;
               sr = 8'h00;
            end
         end else begin
            case (p.dq_out)
               16'h00ff: md = 2'h0;
               16'h0090: md = 2'h1;
               16'h0070: md = 2'h2;
               16'h0050: sr = 8'h80;
               // Suspend parks the machine and answers with status
               16'h00b0: begin
                  susp = 1'b1;
                  md = 2'h2;
               end
               16'h00d0: susp = 1'b0;
               default:  c1 = p.dq_out;
            endcase
         end
      end
   end

   // machine runs alone, selected or not; reset aborts
   always @(posedge mclk) begin
      if (p.reset_powerdown_n !== 1'b1) begin
         bz = 0;
         susp = 1'b0;
         c1 = '0;
         sr = 8'h00;
         md = 2'h0;
      end else if (bz > 0 && !susp) begin
         bz--;
         if (bz == 0) begin
            sr = 8'h80;
            if (oq == 16'h0040) mem[int'(wa)] = c2;
            else if (oq == 16'h0060 && c2 == 16'h0001) lk[blk(wa)] = 1'b1;
            else if (oq == 16'h0060 && c2 == 16'h00d0) lk = '0;
            else if (oq != 16'h0060)
               foreach (mem[k])
                  if (oq == 16'h0030 ? !prot(20'(k)) : blk(20'(k)) == blk(wa))
                     mem[k] = 16'hffff;
         end
      end
   end

   // leaving reset: array mode, status ready
   always @(posedge p.reset_powerdown_n) sr = 8'h80;

   // drive only when read; else a toggling wire
   always @(p, mclk) begin
      if (!p.dq_oe_n) dq = p.dq_out;
      else if (!(p.reset_powerdown_n && !p.ce_n && !p.oe_n && p.we_n)) dq = {16{mclk}};
      else if ((bz > 0 && !susp) || md == 2'h2) dq = {8'h00, sr};
      else if (md == 2'h0) dq = mem.exists(int'(p.addr)) ? mem[int'(p.addr)] : 16'hffff;
      else if (p.addr[1:0] == 2'h0) dq = MFR_CODE;
      else if (p.addr[1:0] == 2'h1) dq = DEV_CODE;
      else dq = {15'h0, !p.addr[0] && lk[blk(p.addr)]};
   end
endmodule
